// ---- core/mcr_checker.sv ----
// Purpose: Decides whether an access is allowed and which map applies
// Assumes: Control bits already registered
// Notes: Combinational; fault is a level valid with the access
`timescale 1ns/100ps
module mcr_checker (
    input wire logic enable_i,
    input wire logic handler_en_i,
    input wire logic backgnd_en_i,
    input wire logic neg_prio_i,
    input wire logic priv_i,
    input wire logic fetch_i,
    input wire logic sys_space_i,
    input wire logic vector_i,
    input wire logic region_found_i,
    input wire logic region_allow_i,
    output logic active_o,
    output logic default_map_o,
    output logic fault_o
);
    always_comb begin
        // Unpredictable handler bit with unit off is treated as off
        active_o = enable_i && (!neg_prio_i || handler_en_i);
        default_map_o = 1'b0;
        fault_o = 1'b0;
        if (sys_space_i && fetch_i) begin
            fault_o = 1'b1;
        end else if (!active_o) begin
            default_map_o = 1'b1;
        end else if (sys_space_i || vector_i) begin
            default_map_o = 1'b1;
        end else if (region_found_i) begin
            fault_o = !region_allow_i;
        end else if (backgnd_en_i && priv_i) begin
            default_map_o = 1'b1;
        end else begin
            fault_o = 1'b1;
        end
    end
endmodule

// ---- core/mcr_pkg.sv ----
// Purpose: Constants for the protection control and region select block
// Assumes: Classic Wishbone slave, 32-bit data, word aligned registers
// Notes: Region match results arrive from the region logic outside
//
// How it works
// - Disabled unit: default map for all but system space fetches, which fault
// - Enabled, no background: unmatched access faults
// - Background map serves privileged accesses only
// - Any enabled region overrides the background
// - Background bit ignored while unit disabled
// - Negative priority handlers unprotected unless enabled
// - Handler bit keeps checks in negative priorities
// - Unprivileged unmatched access faults with background on
// - Privileged unmatched access uses default map with background on
// - Execute never on system space always enforced
// - Background only: privileged passes, unprivileged faults
// - System space and vector table permitted, except fetches from system space
// - Selector field picks region, values 0 to 7
// - Base write with valid bit loads selector
// - Base write without valid keeps selector
// - Highest numbered matching region wins
// - Prohibited access raises memory manage fault
package mcr_pkg;
    localparam int unsigned NUM_REGIONS = 8;
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFS_CONTROL = 8'h04;
    localparam logic [7:0] OFS_SELECT = 8'h08;
    localparam logic [7:0] OFS_BASE = 8'h0c;
    localparam logic [7:0] OFS_ATTR = 8'h10;
    localparam int unsigned BIT_ENABLE = 0;
    localparam int unsigned BIT_HANDLER = 1;
    localparam int unsigned BIT_BACKGND = 2;
    localparam int unsigned BIT_VALID = 4;
    localparam int unsigned SEL_W = 8;
    localparam int unsigned REG_FIELD_W = 4;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam logic [7:0] SEL_MAX = 8'h07;
    localparam logic [31:0] ERR_DATA = 32'h00000000;
endpackage

// ---- core/mcr_region_pick.sv ----
// Purpose: Picks the highest numbered enabled region matching an access
// Assumes: Per-region match and enable come from region logic
// Notes: Pure combinational priority encoder
`timescale 1ns/100ps
module mcr_region_pick (
    input wire logic [7:0] hit_i,
    input wire logic [7:0] en_i,
    output logic found_o,
    output logic [2:0] index_o
);
    logic [7:0] live;
    always_comb begin
        live = hit_i & en_i;
        found_o = |live;
        index_o = 3'h0;
        // Later indices overwrite earlier ones so the highest wins
        for (int i = 0; i < 8; i++) begin
            if (live[i]) begin
                index_o = 3'(i);
            end
        end
    end
endmodule

// ---- core/mcr_top.sv ----
// Purpose: Protection control and region select with Wishbone slave
// Assumes: One clock, synchronous active high reset
// Notes: Ack comes one cycle after the request is seen
`timescale 1ns/100ps
module mcr_top (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic acc_valid_i,
    input wire logic acc_priv_i,
    input wire logic acc_fetch_i,
    input wire logic acc_neg_prio_i,
    input wire logic acc_sys_space_i,
    input wire logic acc_vector_i,
    input wire logic [7:0] region_hit_i,
    input wire logic [7:0] region_en_i,
    input wire logic [7:0] region_allow_i,
    input wire logic [31:0] region_base_rd_i,
    input wire logic [31:0] region_attr_rd_i,
    output logic [7:0] region_sel_o,
    output logic region_base_we_o,
    output logic region_attr_we_o,
    output logic [31:0] region_wdata_o,
    output logic [3:0] region_wsel_o,
    output logic protect_active_o,
    output logic default_map_o,
    output logic [2:0] region_index_o,
    output logic mem_manage_fault_o
);
    ////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [2:0] ctrl;
        logic [7:0] sel;
        logic ack;
        logic [31:0] rdata;
        logic base_we;
        logic attr_we;
        logic [31:0] wdata;
        logic [3:0] wsel;
    } mcr_state_t;

    mcr_state_t st_q;
    mcr_state_t st_d;
    logic req;
    logic found;
    logic [2:0] idx;
    logic active;
    logic dmap;
    logic fault;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    assign req = wb_cyc_i && wb_stb_i && !st_q.ack;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [31:0] cw;
        cw = 32'h00000000;
        st_d = st_q;
        st_d.ack = req;
        st_d.base_we = 1'b0;
        st_d.attr_we = 1'b0;
        if (req && wb_we_i) begin
            st_d.wdata = wb_dat_i;
            st_d.wsel = wb_sel_i;
            unique case (wb_adr_i)
                mcr_pkg::OFS_CONTROL: begin
                    cw = merge({29'h0, st_q.ctrl}, wb_dat_i, wb_sel_i);
                    st_d.ctrl = cw[2:0];
                end
                mcr_pkg::OFS_SELECT: begin
                    // Only 0 to 7 are legal; wider values are kept low
                    if (wb_sel_i[0]) begin
                        st_d.sel = {5'h00, wb_dat_i[2:0]};
                    end
                end
                mcr_pkg::OFS_BASE: begin
                    if (wb_sel_i[0] && wb_dat_i[mcr_pkg::BIT_VALID]) begin
                        st_d.sel = {5'h00, wb_dat_i[2:0]};
                    end
                    st_d.base_we = 1'b1;
                end
                mcr_pkg::OFS_ATTR: begin
                    st_d.attr_we = 1'b1;
                end
                default: begin
                end
            endcase
        end
        st_d.rdata = mcr_pkg::ERR_DATA;
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                mcr_pkg::OFS_CONTROL: st_d.rdata = {29'h0, st_q.ctrl};
                mcr_pkg::OFS_SELECT: st_d.rdata = {24'h0, st_q.sel};
                mcr_pkg::OFS_BASE: st_d.rdata =
                    {region_base_rd_i[31:5], 1'b0, st_q.sel[3:0]};
                mcr_pkg::OFS_ATTR: st_d.rdata = region_attr_rd_i;
                default: st_d.rdata = mcr_pkg::ERR_DATA;
            endcase
        end
        if (reset_i) begin
            st_d = '0;
            st_d.ctrl = mcr_pkg::CTRL_RESET;
            st_d.sel = mcr_pkg::SEL_RESET;
        end
    end

    always_ff @(posedge core_clk_i) begin
        st_q <= st_d;
    end

    ////////////////////////////////////////////////////////////////////
    mcr_region_pick u_pick (
        .hit_i(region_hit_i),
        .en_i(region_en_i),
        .found_o(found),
        .index_o(idx)
    );

    mcr_checker u_check (
        .enable_i(st_q.ctrl[mcr_pkg::BIT_ENABLE]),
        .handler_en_i(st_q.ctrl[mcr_pkg::BIT_HANDLER]),
        .backgnd_en_i(st_q.ctrl[mcr_pkg::BIT_BACKGND]),
        .neg_prio_i(acc_neg_prio_i),
        .priv_i(acc_priv_i),
        .fetch_i(acc_fetch_i),
        .sys_space_i(acc_sys_space_i),
        .vector_i(acc_vector_i),
        .region_found_i(found),
        .region_allow_i(region_allow_i[idx]),
        .active_o(active),
        .default_map_o(dmap),
        .fault_o(fault)
    );

    assign wb_dat_o = st_q.rdata;
    assign wb_ack_o = st_q.ack;
    assign region_sel_o = st_q.sel;
    assign region_base_we_o = st_q.base_we;
    assign region_attr_we_o = st_q.attr_we;
    assign region_wdata_o = st_q.wdata;
    assign region_wsel_o = st_q.wsel;
    assign protect_active_o = active;
    assign default_map_o = dmap;
    assign region_index_o = idx;
    assign mem_manage_fault_o = acc_valid_i && fault;

    ////////////////////////////////////////////////////////////////////
    AST_OFF_NO_FAULT: assert property (@(posedge core_clk_i)
        disable iff (reset_i)
        (!st_q.ctrl[0] && acc_valid_i && !(acc_sys_space_i && acc_fetch_i))
        |-> !mem_manage_fault_o)
        else $error("Fault while protection off");
    AST_NO_BG_FAULT: assert property (@(posedge core_clk_i)
        disable iff (reset_i)
        (protect_active_o && !st_q.ctrl[2] && acc_valid_i && !found
         && !acc_sys_space_i && !acc_vector_i) |-> mem_manage_fault_o)
        else $error("Unmatched access did not fault");
    AST_BG_PRIV: assert property (@(posedge core_clk_i)
        disable iff (reset_i)
        (protect_active_o && st_q.ctrl[2] && acc_priv_i && !found
         && !acc_sys_space_i) |-> default_map_o && !mem_manage_fault_o)
        else $error("Privileged background access refused");
    AST_BG_UNPRIV: assert property (@(posedge core_clk_i)
        disable iff (reset_i)
        (protect_active_o && acc_valid_i && !acc_priv_i && !found
         && !acc_sys_space_i && !acc_vector_i) |-> mem_manage_fault_o)
        else $error("Unprivileged unmatched access passed");
    AST_HANDLER: assert property (@(posedge core_clk_i)
        disable iff (reset_i)
        (acc_neg_prio_i && !st_q.ctrl[1]) |-> !protect_active_o)
        else $error("Protection active in handler");
    AST_HANDLER_ON: assert property (@(posedge core_clk_i)
        disable iff (reset_i)
        (st_q.ctrl[0] && st_q.ctrl[1]) |-> protect_active_o)
        else $error("Protection dropped in handler");
    AST_SYS_OK: assert property (@(posedge core_clk_i)
        disable iff (reset_i)
        (acc_valid_i && (acc_vector_i || acc_sys_space_i) && !acc_fetch_i)
        |-> !mem_manage_fault_o)
        else $error("System or vector access faulted");
    AST_XN_SYS: assert property (@(posedge core_clk_i)
        disable iff (reset_i)
        (acc_valid_i && acc_sys_space_i && acc_fetch_i)
        |-> mem_manage_fault_o)
        else $error("Fetch from system space allowed");
    AST_REGION_WINS: assert property (@(posedge core_clk_i)
        disable iff (reset_i)
        (protect_active_o && found && !acc_sys_space_i && !acc_vector_i)
        |-> !default_map_o)
        else $error("Background used over an enabled region");
    AST_SEL_VALID: assert property (@(posedge core_clk_i)
        disable iff (reset_i)
        (req && wb_we_i && wb_adr_i == mcr_pkg::OFS_BASE && wb_sel_i[0]
         && wb_dat_i[mcr_pkg::BIT_VALID])
        |=> region_sel_o == {5'h00, $past(wb_dat_i[2:0])})
        else $error("Selector not loaded by base write");
    AST_SEL_KEEP: assert property (@(posedge core_clk_i)
        disable iff (reset_i)
        (req && wb_we_i && wb_adr_i == mcr_pkg::OFS_BASE
         && !(wb_sel_i[0] && wb_dat_i[mcr_pkg::BIT_VALID]))
        |=> $stable(region_sel_o) && region_base_we_o)
        else $error("Selector changed without valid bit");
    AST_SEL_RANGE: assert property (@(posedge core_clk_i)
        disable iff (reset_i)
        region_sel_o <= mcr_pkg::SEL_MAX)
        else $error("Selector out of range");
    AST_RESET: assert property (@(posedge core_clk_i)
        reset_i |=> st_q.ctrl == 3'h0 && region_sel_o == 8'h00)
        else $error("Reset did not clear registers");
    AST_ACK: assert property (@(posedge core_clk_i)
        disable iff (reset_i)
        (req) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("Ack not single cycle");
    // Stale read data on an idle bus would mask a missed ack
    AST_IDLE_DATA: assert property (@(posedge core_clk_i)
        disable iff (reset_i)
        !wb_ack_o |-> wb_dat_o == mcr_pkg::ERR_DATA)
        else $error("Read data standing without ack");

    COV_FAULT: cover property (@(posedge core_clk_i) mem_manage_fault_o);
    COV_BG: cover property (@(posedge core_clk_i)
        protect_active_o && default_map_o && !found);
    COV_OVERLAP: cover property (@(posedge core_clk_i)
        $countones(region_hit_i & region_en_i) > 1);
    COV_VALID: cover property (@(posedge core_clk_i)
        region_base_we_o && region_sel_o != 8'h00);
endmodule

// ---- dv/mcr_region_model.sv ----
// Purpose: Region storage standing in for the outside region logic
// Assumes: Write pulses and selector come from the control block
// Notes: Byte lanes of each write pulse are honoured
`timescale 1ns/100ps
module mcr_region_model (
    input wire logic clk_i,
    input wire logic [7:0] sel_i,
    input wire logic base_we_i,
    input wire logic attr_we_i,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wsel_i,
    output logic [31:0] base_rd_o,
    output logic [31:0] attr_rd_o
);
    logic [31:0] base_q [8];
    logic [31:0] attr_q [8];
    // Selector already holds any retarget when the pulse arrives
    always_ff @(posedge clk_i) begin
        for (int b = 0; b < 4; b++) begin
            if (base_we_i && wsel_i[b]) begin
                base_q[sel_i[2:0]][b*8 +: 8] <= wdata_i[b*8 +: 8];
            end
            if (attr_we_i && wsel_i[b]) begin
                attr_q[sel_i[2:0]][b*8 +: 8] <= wdata_i[b*8 +: 8];
            end
        end
    end
    // Only the selected region is visible to the register path
    assign base_rd_o = base_q[sel_i[2:0]];
    assign attr_rd_o = attr_q[sel_i[2:0]];
endmodule

// ---- dv/mcr_top_bench.sv ----
// Purpose: Self-checking bench for the protection control block
// Assumes: Ack one cycle after request; access checks combinational
// Notes: Handler bit never set with enable off, as software must not
`timescale 1ns/100ps
module mcr_top_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h00000000, rd;
    logic vld = 1'b0, priv = 1'b0, fetch = 1'b0, neg = 1'b0;
    logic sys = 1'b0, vec = 1'b0;
    logic [7:0] hit = 8'h00, ren = 8'h00, allow = 8'h00;
    logic [31:0] wb_dat_o, base_rd, attr_rd, wdata;
    logic wb_ack_o, base_we, attr_we, active, fault;
    logic dmap;
    logic [3:0] be = 4'hf, lanes = 4'hf, wsel;
    logic [7:0] sel;
    logic [2:0] index;
    int bad_count = 0;
    int n_tests = 0;
    int cyc_n = 0;
    always #4 clk = ~clk;
    mcr_top DUT (.core_clk_i(clk), .reset_i(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(be),
        .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .acc_valid_i(vld), .acc_priv_i(priv), .acc_fetch_i(fetch),
        .acc_neg_prio_i(neg), .acc_sys_space_i(sys), .acc_vector_i(vec),
        .region_hit_i(hit), .region_en_i(ren), .region_allow_i(allow),
        .region_base_rd_i(base_rd), .region_attr_rd_i(attr_rd),
        .region_sel_o(sel), .region_base_we_o(base_we),
        .region_attr_we_o(attr_we), .region_wdata_o(wdata),
        .region_wsel_o(wsel), .protect_active_o(active), .default_map_o(dmap),
        .region_index_o(index), .mem_manage_fault_o(fault));
    mcr_region_model regions (.clk_i(clk), .sel_i(sel),
        .base_we_i(base_we), .attr_we_i(attr_we), .wdata_i(wdata),
        .wsel_i(wsel), .base_rd_o(base_rd), .attr_rd_o(attr_rd));
    ////////////////////////////////////////////////////////////////////
    task automatic test_done;
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Generous ceiling; the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n > 20000) begin
            bad_count++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        be <= lanes;
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        wb(1'b0, mcr_pkg::OFS_CONTROL, 32'h0);
        chk(rd, 32'h00000000);
        wb(1'b0, mcr_pkg::OFS_SELECT, 32'h0);
        chk(rd, 32'h00000000);
        chk({24'h0, sel}, 32'h00000000);
    endtask
    task automatic t_regs;
        wb(1'b1, mcr_pkg::OFS_CONTROL, 32'hffffffff);
        wb(1'b0, mcr_pkg::OFS_CONTROL, 32'h0);
        chk(rd, 32'h00000007);
        wb(1'b1, mcr_pkg::OFS_SELECT, 32'h0000000f);
        wb(1'b0, mcr_pkg::OFS_SELECT, 32'h0);
        chk(rd, 32'h00000007);
        wb(1'b1, mcr_pkg::OFS_ATTR, 32'h1234beef);
        wb(1'b0, mcr_pkg::OFS_ATTR, 32'h0);
        chk(rd, 32'h1234beef);
        // Unmapped place: acked, write dropped, reads zero
        wb(1'b1, 8'h40, 32'hdeadbeef);
        wb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h00000000);
    endtask
    task automatic t_base;
        wb(1'b1, mcr_pkg::OFS_BASE, 32'habcd0013);
        chk({24'h0, sel}, 32'h00000003);
        wb(1'b0, mcr_pkg::OFS_BASE, 32'h0);
        chk(rd, 32'habcd0003);
        wb(1'b1, mcr_pkg::OFS_BASE, 32'h55aa0026);
        wb(1'b0, mcr_pkg::OFS_BASE, 32'h0);
        chk(rd, 32'h55aa0023);
        chk({24'h0, sel}, 32'h00000003);
        // Valid bit set but its byte lane off: selector must stay
        lanes = 4'he;
        wb(1'b1, mcr_pkg::OFS_BASE, 32'h77660015);
        lanes = 4'hf;
        chk({24'h0, sel}, 32'h00000003);
        wb(1'b0, mcr_pkg::OFS_BASE, 32'h0);
        chk(rd, 32'h77660023);
    endtask
    task automatic t_rerst;
        wb(1'b1, mcr_pkg::OFS_CONTROL, 32'h00000005);
        wb(1'b1, mcr_pkg::OFS_SELECT, 32'h00000006);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk({24'h0, sel}, 32'h00000000);
        wb(1'b0, mcr_pkg::OFS_CONTROL, 32'h0);
        chk(rd, 32'h00000000);
        wb(1'b0, mcr_pkg::OFS_SELECT, 32'h0);
        chk(rd, 32'h00000000);
    endtask
    ////////////////////////////////////////////////////////////////////
    // p: [0] negative priority, [1] privileged, [2] system space,
    // [3] vector table, [4] regions 2 and 5 enabled (both always hit), only 2 allows
    function automatic logic exp_fault(logic [2:0] c, logic [4:0] p);
        logic act;
        act = c[0] && !(p[0] && !c[1]);
        if (p[2] && p[3]) begin
            return 1'b1;
        end
        if (!act || p[2] || p[3]) begin
            return 1'b0;
        end
        if (p[4]) begin
            return 1'b1;
        end
        return !(c[2] && p[1]);
    endfunction
    function automatic logic exp_dmap(logic [2:0] c, logic [4:0] p);
        logic act;
        act = c[0] && !(p[0] && !c[1]);
        if (p[2] && p[3]) begin
            return 1'b0;
        end
        if (!act || p[2] || p[3]) begin
            return 1'b1;
        end
        return !p[4] && c[2] && p[1];
    endfunction
    task automatic t_access;
        // Handler bit only ever set with enable on
        // Enable-only rows show why software must add a region
        logic [2:0] ctl [6] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h7};
        logic [4:0] p;
        for (int i = 0; i < 6; i++) begin
            wb(1'b1, mcr_pkg::OFS_CONTROL, {29'h0, ctl[i]});
            for (int k = 0; k < 32; k++) begin
                p = k[4:0];
                @(posedge clk);
                vld <= 1'b1;
                neg <= p[0];
                priv <= p[1];
                sys <= p[2];
                vec <= p[3];
                fetch <= p[2] & p[3];
                hit <= 8'h24;
                ren <= p[4] ? 8'h24 : 8'h00;
                allow <= 8'h04;
                #1;
                chk({31'h0, fault}, {31'h0, exp_fault(ctl[i], p)});
                chk({31'h0, active}, {31'h0, ctl[i][0]
                    && !(p[0] && !ctl[i][1])});
                chk({31'h0, dmap}, {31'h0, exp_dmap(ctl[i], p)});
                if (p[4]) begin
                    chk({29'h0, index}, 32'h00000005);
                end
            end
        end
        @(posedge clk);
        vld <= 1'b0;
        #1;
        chk({31'h0, fault}, 32'h00000000);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_base();
        t_access();
        t_rerst();
        test_done();
    end
endmodule
